// ===== hw/cog_pkg.sv
// shared constants and types of the complementary waveform unit
// Notes on behaviour
// - four outputs A to D, content chosen by the current mode
// - period follows rising events; active time runs rising to falling event
// - one signal may feed both event kinds; sources may be asynchronous
// - timers count reference ticks; dead band may instead count every clock
// - steered mode routes the pwm to any outputs, next cycle after write
// - synchronous steering changes at the next rising event; static data does not
// - mode 000 is steered, 001 is synchronous steered
// - mode 010 is forward full bridge, 011 is reverse full bridge
// - full bridge: two outputs idle, one modulated, one held on
// - full bridge direction change delays the modulated output by dead band
// - forward: D modulated, A held on
// - reverse: B modulated, C held on
// - mode 100 is half bridge, complementary pair from one pwm
// - half bridge turn-on waits a dead band after the other turns off
// - half bridge primary on A and C, complementary on B and D
// - mode 101 is push-pull; A mirrors C and B mirrors D
// - push-pull drives rising to falling, alternating pairs each period
// - optional blanking of falling after rise drive, and of rising after fall
// - optional phase delay postpones drive start after the rising event
// - fault sources shut down drive and force a chosen override, optional restart
// - per-source edge or level sensing, per-output polarity
// - when disabled primary outputs inactive and complementary outputs active
// - set sensitivity bit means edge, cleared means level
// - enabled rising sources ORed together, enabled falling sources likewise
// - set polarity bit makes the output active low
package cog_pkg;
    localparam int SRC_N = 8;
    localparam int SHUT_N = 4;
    localparam int CNT_W = 6;
    localparam int ADR_W = 6;
    localparam int REG_N = 8;
    // register byte offsets
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_STEER = 6'h04;
    localparam logic [5:0] OFS_RISE = 6'h08;
    localparam logic [5:0] OFS_FALL = 6'h0C;
    localparam logic [5:0] OFS_DBAND = 6'h10;
    localparam logic [5:0] OFS_BLANK = 6'h14;
    localparam logic [5:0] OFS_PHASE = 6'h18;
    localparam logic [5:0] OFS_SHUT = 6'h1C;
    localparam logic [5:0] OFS_STAT = 6'h20;
    // field positions
    localparam int F_EN = 0;
    localparam int F_MD = 1;
    localparam int F_CS = 4;
    localparam int F_RDBS = 6;
    localparam int F_FDBS = 7;
    localparam int F_POL = 8;
    localparam int F_SDAT = 4;
    localparam int F_SIM = 8;
    localparam int F_HI = 8;
    localparam int F_ARS = 4;
    localparam int F_OVR = 8;
    localparam int F_SHUT = 16;
    // implemented bits per register, others read zero except the shutdown state bit; reset value is zero
    localparam logic [31:0] IMPL [REG_N] = '{32'h0000_0FFF, 32'h0000_00FF,
        32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_3F3F, 32'h0000_3F3F,
        32'h0000_3F3F, 32'h0000_FF1F};
    localparam logic [31:0] REG_RST = 32'h0000_0000;
    typedef enum logic [2:0] {
        MD_STEER = 3'h0, MD_SYNC = 3'h1, MD_FWD = 3'h2,
        MD_REV = 3'h3, MD_HALF = 3'h4, MD_PUSH = 3'h5
    } op_mode_t;
    // shutdown override codes
    localparam logic [1:0] OVR_INACT = 2'h0;
    localparam logic [1:0] OVR_LOW = 2'h1;
    localparam logic [1:0] OVR_HIGH = 2'h2;
    localparam logic [1:0] OVR_HIZ = 2'h3;
    typedef enum logic [1:0] {ST_OFF, ST_RPH, ST_ON, ST_FPH} drive_st_t;
    typedef struct packed {
        logic d;
        logic c;
        logic b;
        logic a;
    } quad_t;
endpackage

// ===== hw/complementary_waveform_unit.sv
// complementary waveform unit with wishbone register slave
//
// Implementation choices: the address map and the Wishbone interface to the registers.
module complementary_waveform_unit (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    // wishbone slave
    input  wire logic                       cyc_i,
    input  wire logic                       stb_i,
    input  wire logic                       we_i,
    input  wire logic [cog_pkg::ADR_W-1:0]  adr_i,
    input  wire logic [3:0]                 sel_i,
    input  wire logic [31:0]                dat_i,
    output logic      [31:0]                dat_o,
    output logic                            ack_o,
    // event and fault sources
    input  wire logic [cog_pkg::SRC_N-1:0]  rise_src,
    input  wire logic [cog_pkg::SRC_N-1:0]  fall_src,
    input  wire logic [cog_pkg::SHUT_N-1:0] shut_src,
    // outputs: level and drive enable
    output cog_pkg::quad_t                  pin_level,
    output cog_pkg::quad_t                  pin_drive
);
    localparam int IN_W = 2 * cog_pkg::SRC_N + cog_pkg::SHUT_N;
    localparam int CW = cog_pkg::CNT_W;

    logic [31:0]              cfg [cog_pkg::REG_N];
    logic [IN_W-1:0]          in_m;
    logic [IN_W-1:0]          in_s;
    logic [IN_W-1:0]          in_q;
    logic [2:0]               div_cnt;
    logic [2:0]               div_mask;
    logic                     tick;
    cog_pkg::drive_st_t       st;
    cog_pkg::drive_st_t       next_st;
    logic [CW-1:0]            ph_cnt;
    logic [CW-1:0]            rblank;
    logic [CW-1:0]            fblank;
    logic [CW-1:0]            rdb_cnt;
    logic [CW-1:0]            fdb_cnt;
    logic [CW-1:0]            fb_cnt;
    logic                     prim_on;
    logic                     comp_on;
    logic                     fb_rev;
    logic                     pp_sel;
    logic                     shut;
    logic [3:0]               str_act;
    logic [3:0]               act;
    logic [3:0]               next_level;
    logic [3:0]               next_drive;
    logic [31:0]              next_dat;
    logic                     wr;
    logic                     rise_hit;
    logic                     fall_hit;
    logic                     shut_hit;
    logic                     run;
    logic                     drive;
    logic                     go_on;
    logic                     go_off;
    logic                     fb_hold;
    logic                     fb_turn;

    // configuration fields
    wire                      en = cfg[0][cog_pkg::F_EN];
    wire cog_pkg::op_mode_t   mode = cog_pkg::op_mode_t'(cfg[0][cog_pkg::F_MD +: 3]);
    wire [1:0]                cs = cfg[0][cog_pkg::F_CS +: 2];
    wire                      rdbs = cfg[0][cog_pkg::F_RDBS];
    wire                      fdbs = cfg[0][cog_pkg::F_FDBS];
    wire [3:0]                pol = cfg[0][cog_pkg::F_POL +: 4];
    wire [3:0]                str = cfg[1][3:0];
    wire [3:0]                sdat = cfg[1][cog_pkg::F_SDAT +: 4];
    wire [cog_pkg::SRC_N-1:0] r_en = cfg[2][cog_pkg::SRC_N-1:0];
    wire [cog_pkg::SRC_N-1:0] r_sim = cfg[2][cog_pkg::F_SIM +: cog_pkg::SRC_N];
    wire [cog_pkg::SRC_N-1:0] f_en = cfg[3][cog_pkg::SRC_N-1:0];
    wire [cog_pkg::SRC_N-1:0] f_sim = cfg[3][cog_pkg::F_SIM +: cog_pkg::SRC_N];
    wire [CW-1:0]             rdb = cfg[4][CW-1:0];
    wire [CW-1:0]             fdb = cfg[4][cog_pkg::F_HI +: CW];
    wire [CW-1:0]             rbk = cfg[5][CW-1:0];
    wire [CW-1:0]             fbk = cfg[5][cog_pkg::F_HI +: CW];
    wire [CW-1:0]             rph = cfg[6][CW-1:0];
    wire [CW-1:0]             fph = cfg[6][cog_pkg::F_HI +: CW];
    wire [cog_pkg::SHUT_N-1:0] sh_en = cfg[7][cog_pkg::SHUT_N-1:0];
    wire                      ars = cfg[7][cog_pkg::F_ARS];
    wire [7:0]                ovr = cfg[7][cog_pkg::F_OVR +: 8];

    // bus write strobe, lands at the edge that completes the cycle
    assign wr = cyc_i && stb_i && we_i && ack_o;

    // classic wishbone answer one cycle after the request
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
            dat_o <= next_dat;
        end
    end

    // register file with byte lanes; reserved bits stay zero
    always_ff @(posedge clk) begin
        for (int i = 0; i < cog_pkg::REG_N; i++) begin
            if (!rst_n) begin
                cfg[i] <= cog_pkg::REG_RST;
            end else if (wr && !adr_i[5] && adr_i[4:2] == 3'(i)) begin
                for (int b = 0; b < 4; b++) begin
                    if (sel_i[b]) begin
                        cfg[i][b*8 +: 8] <= dat_i[b*8 +: 8] & cog_pkg::IMPL[i][b*8 +: 8];
                    end
                end
            end
        end
    end

    // read mux; unmapped reads return zero
    always_comb begin
        next_dat = 32'h0000_0000;
        if (adr_i == cog_pkg::OFS_STAT) begin
            next_dat = {22'h00_0000, fb_rev, fb_hold, pp_sel, comp_on, prim_on, drive, act};
        end else if (!adr_i[5]) begin
            next_dat = cfg[adr_i[4:2]];
            if (adr_i == cog_pkg::OFS_SHUT) begin
                next_dat[cog_pkg::F_SHUT] = shut;
            end
        end
    end

    // two-stage synchronisers plus one history stage for edges
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            in_m <= '0;
            in_s <= '0;
            in_q <= '0;
        end else begin
            in_m <= {shut_src, fall_src, rise_src};
            in_s <= in_m;
            in_q <= in_s;
        end
    end

    // sources ORed; edge mode needs a fresh rise, level mode the high level
    assign rise_hit = |(r_en & in_s[7:0] & ~(in_q[7:0] & r_sim));
    assign fall_hit = |(f_en & in_s[15:8] & ~(in_q[15:8] & f_sim));
    assign shut_hit = |(sh_en & in_s[19:16]);

    // reference clock enable: divide by 1, 2, 4 or 8
    assign div_mask = {cs == 2'h3, cs[1], cs != 2'h0};
    assign tick = (div_cnt & div_mask) == 3'h0;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_cnt <= 3'h0;
        end else begin
            div_cnt <= div_cnt + 3'h1;
        end
    end

    assign run = en && !shut;
    assign drive = (st == cog_pkg::ST_ON) || (st == cog_pkg::ST_FPH);

    // drive sequencer with phase delay and blanking
    always_comb begin
        next_st = st;
        case (st)
            cog_pkg::ST_OFF: begin
                if (rise_hit && rblank == '0) begin
                    next_st = (rph == '0) ? cog_pkg::ST_ON : cog_pkg::ST_RPH;
                end
            end
            cog_pkg::ST_RPH: begin
                if (ph_cnt == '0) begin
                    next_st = cog_pkg::ST_ON;
                end
            end
            cog_pkg::ST_ON: begin
                if (fall_hit && fblank == '0) begin
                    next_st = (fph == '0) ? cog_pkg::ST_OFF : cog_pkg::ST_FPH;
                end
            end
            cog_pkg::ST_FPH: begin
                if (ph_cnt == '0) begin
                    next_st = cog_pkg::ST_OFF;
                end
            end
            default: next_st = cog_pkg::ST_OFF;
        endcase
        if (!run) begin
            next_st = cog_pkg::ST_OFF;
        end
    end

    assign go_on = next_st == cog_pkg::ST_ON && st != cog_pkg::ST_ON;
    assign go_off = next_st == cog_pkg::ST_OFF && st != cog_pkg::ST_OFF;

    // sequencer state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= cog_pkg::ST_OFF;
        end else begin
            st <= next_st;
        end
    end

    // phase delay counter on reference ticks
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ph_cnt <= '0;
        end else if (st == cog_pkg::ST_OFF && next_st == cog_pkg::ST_RPH) begin
            ph_cnt <= rph;
        end else if (st == cog_pkg::ST_ON && next_st == cog_pkg::ST_FPH) begin
            ph_cnt <= fph;
        end else if (tick && ph_cnt != '0) begin
            ph_cnt <= ph_cnt - 1'b1;
        end
    end

    // blanking windows after each drive edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fblank <= '0;
            rblank <= '0;
        end else begin
            if (go_on) begin
                fblank <= fbk;
            end else if (tick && fblank != '0) begin
                fblank <= fblank - 1'b1;
            end
            if (go_off) begin
                rblank <= rbk;
            end else if (tick && rblank != '0) begin
                rblank <= rblank - 1'b1;
            end
        end
    end

    // dead-band counters: reference ticks or every clock as the delay chain
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdb_cnt <= '0;
            fdb_cnt <= '0;
        end else begin
            if (go_on) begin
                rdb_cnt <= rdb;
            end else if ((rdbs || tick) && rdb_cnt != '0) begin
                rdb_cnt <= rdb_cnt - 1'b1;
            end
            if (go_off) begin
                fdb_cnt <= fdb;
            end else if ((fdbs || tick) && fdb_cnt != '0) begin
                fdb_cnt <= fdb_cnt - 1'b1;
            end
        end
    end

    // half-bridge phases with dead band; idle shows complementary active
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prim_on <= 1'b0;
            comp_on <= 1'b1;
        end else begin
            prim_on <= en && drive && (prim_on || rdb_cnt == '0);
            comp_on <= !en || (!drive && (comp_on || fdb_cnt == '0));
        end
    end

    // full-bridge direction and dead band on reversal; the turn cycle already holds
    assign fb_turn = (mode == cog_pkg::MD_FWD || mode == cog_pkg::MD_REV)
                     && fb_rev != (mode == cog_pkg::MD_REV);
    assign fb_hold = fb_cnt != '0 || fb_turn;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fb_rev <= 1'b0;
            fb_cnt <= '0;
        end else if (fb_turn) begin
            fb_rev <= mode == cog_pkg::MD_REV;
            fb_cnt <= (mode == cog_pkg::MD_REV) ? fdb : rdb;
        end else if (((fb_rev ? fdbs : rdbs) || tick) && fb_cnt != '0) begin
            fb_cnt <= fb_cnt - 1'b1;
        end
    end

    // push-pull pair select, flips on each new period
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pp_sel <= 1'b1;
        end else if (go_on && mode == cog_pkg::MD_PUSH) begin
            pp_sel <= !pp_sel;
        end
    end

    // steering: direct after a write, or at the rising event when synchronous
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            str_act <= 4'h0;
        end else if (mode != cog_pkg::MD_SYNC || go_on) begin
            str_act <= str;
        end
    end

    // shutdown latch: fault wins over software clear and restart
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shut <= 1'b0;
        end else if (shut_hit) begin
            shut <= 1'b1;
        end else if (wr && adr_i == cog_pkg::OFS_SHUT && sel_i[2]) begin
            shut <= dat_i[cog_pkg::F_SHUT];
        end else if (ars && rise_hit) begin
            shut <= 1'b0;
        end
    end

    // logical output activity per mode, bits A B C D from 0
    always_comb begin
        act = 4'h0;
        case (mode)
            cog_pkg::MD_STEER, cog_pkg::MD_SYNC: begin
                for (int i = 0; i < 4; i++) begin
                    act[i] = str_act[i] ? (drive && en) : sdat[i];
                end
            end
            cog_pkg::MD_FWD: act = {drive && !fb_hold, 2'b00, en};
            cog_pkg::MD_REV: act = {1'b0, en, drive && !fb_hold, 1'b0};
            cog_pkg::MD_HALF: act = {comp_on, prim_on, comp_on, prim_on};
            cog_pkg::MD_PUSH: act = {drive && pp_sel, drive && !pp_sel,
                                     drive && pp_sel, drive && !pp_sel};
            default: act = 4'h0;
        endcase
    end

    // per-output polarity and shutdown override
    for (genvar g = 0; g < 4; g++) begin : g_out
        always_comb begin
            next_drive[g] = 1'b1;
            next_level[g] = act[g] ^ pol[g];
            if (shut) begin
                case (ovr[g*2 +: 2])
                    cog_pkg::OVR_INACT: next_level[g] = pol[g];
                    cog_pkg::OVR_LOW: next_level[g] = 1'b0;
                    cog_pkg::OVR_HIGH: next_level[g] = 1'b1;
                    default: begin
                        next_level[g] = 1'b0;
                        next_drive[g] = 1'b0;
                    end
                endcase
            end
        end
    end

    // registered pins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_level <= '0;
            pin_drive <= '1;
        end else begin
            pin_level <= cog_pkg::quad_t'(next_level);
            pin_drive <= cog_pkg::quad_t'(next_drive);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_disable_idle: assert property (!en |=> !prim_on && comp_on)
        else $error("disabled unit not idle");
    a_undef_mode: assert property (mode[2:1] == 2'b11 |-> act == 4'h0)
        else $error("undefined mode drives outputs");
    a_fwd_bridge: assert property (mode == cog_pkg::MD_FWD && en |-> act[0] && act[2:1] == 2'b00)
        else $error("forward bridge pattern wrong");
    a_rev_bridge: assert property (mode == cog_pkg::MD_REV && en |-> act[2] && !act[0] && !act[3])
        else $error("reverse bridge pattern wrong");
    a_pp_mirror: assert property (mode == cog_pkg::MD_PUSH |-> act[0] == act[2] && act[1] == act[3])
        else $error("push-pull pairs differ");
    a_pp_alternate: assert property (mode == cog_pkg::MD_PUSH && go_on |=> pp_sel != $past(pp_sel))
        else $error("push-pull pair not switched");
    a_sync_steer: assert property (mode == cog_pkg::MD_SYNC && !go_on |=> $stable(str_act))
        else $error("sync steering changed off event");
    a_shut_drive: assert property (shut |=> st == cog_pkg::ST_OFF)
        else $error("drive continues in shutdown");
    a_pin_polar: assert property (!shut |=> pin_level == $past(act ^ pol))
        else $error("pin level not act xor polarity");
    a_fall_blank: assert property (st == cog_pkg::ST_ON && fblank != '0 && en && !shut |=> st == cog_pkg::ST_ON)
        else $error("falling event not blanked");
    a_hb_deadband: assert property ($rose(prim_on) |-> !comp_on)
        else $error("half bridge outputs overlap");

    c_push_pull: cover property (mode == cog_pkg::MD_PUSH && go_on ##[1:200] go_on);
    c_fb_reverse: cover property (fb_hold && mode == cog_pkg::MD_REV);
    c_shutdown: cover property ($rose(shut) ##[1:200] $fell(shut));
    c_half: cover property (mode == cog_pkg::MD_HALF && $rose(comp_on));
endmodule

// ===== verification/pwm_event_source.sv
// partner model: periodic pwm event source feeding the unit
module pwm_event_source (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // control
    input  wire logic       run,
    input  wire logic [7:0] period,
    input  wire logic [7:0] high_time,
    // event output
    output logic            pwm
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt;
    // period counter, wraps at period
    always_ff @(posedge clk) begin
        if (!rst_n || !run || cnt == period - 8'h01) begin
            cnt <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
    // high from period start for high_time cycles
    always_ff @(posedge clk) begin
        pwm <= rst_n && run && (cnt < high_time);
    end
endmodule

// ===== verification/test_complementary_waveform_unit.sv
// self-checking bench for the complementary waveform unit
module test_complementary_waveform_unit;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  cyc_i = 1'b0;
    logic                  stb_i = 1'b0;
    logic                  we_i = 1'b0;
    logic [5:0]            adr_i = 6'h00;
    logic [3:0]            sel_i = 4'h0;
    logic [31:0]           dat_i = 32'h0000_0000;
    logic [31:0]           dat_o;
    logic                  ack_o;
    logic [3:0]            shut_src = 4'h0;
    logic                  run = 1'b0;
    logic                  pwm;
    cog_pkg::quad_t        pin_level;
    cog_pkg::quad_t        pin_drive;
    logic [31:0]           q;
    int                    bad_count = 0;
    int                    n_checks = 0;
    // mode, level while on, level while off
    logic [11:0]           tab [4] = '{12'h291, 12'h364, 12'h45A, 12'h600};

    always #2.5 clk = ~clk;

    pwm_event_source src (.clk(clk), .rst_n(rst_n), .run(run), .period(8'h40), .high_time(8'h20), .pwm(pwm));

    complementary_waveform_unit DUT (.clk(clk), .rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .rise_src({7'h00, pwm}), .fall_src({7'h00, ~pwm}), .shut_src(shut_src),
        .pin_level(pin_level), .pin_drive(pin_drive));

    // verdict and end of run
    task final_report;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task pins(input logic [3:0] e, input string m);
        chk({28'h0, pin_level}, {28'h0, e}, m);
    endtask

    // one classic wishbone cycle, waits for ack under a bound
    task wb(input logic w, input logic [5:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'hF;
        dat_i <= d;
        do begin
            @(posedge clk);
            k++;
        end while (ack_o !== 1'b1 && k < 20);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (k >= 20) begin
            bad_count++;
            $display("mismatch t=%0t bus timeout", $time);
            final_report;
        end
    endtask

    // wait for pwm to reach level v fresh, then d cycles
    task at(input logic v, input int d);
        int k;
        k = 0;
        while (pwm === v && k < 300) begin
            @(posedge clk);
            k++;
        end
        while (pwm !== v && k < 300) begin
            @(posedge clk);
            k++;
        end
        if (k >= 300) begin
            bad_count++;
            $display("mismatch t=%0t event timeout", $time);
            final_report;
        end
        repeat (d) @(posedge clk);
    endtask

    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        chk({28'h0, pin_drive}, 32'h0000_000F, "drive in reset");
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            wb(1'b0, 6'(i * 4), 32'h0);
            chk(q, cog_pkg::REG_RST, "reset value");
        end
        wb(1'b1, cog_pkg::OFS_STEER, 32'hFFFF_FFFF);
        wb(1'b0, cog_pkg::OFS_STEER, 32'h0);
        chk(q, cog_pkg::IMPL[1], "steer bits");
        wb(1'b1, 6'h3C, 32'hFFFF_FFFF);
        wb(1'b0, 6'h3C, 32'h0);
        chk(q, 32'h0, "unmapped");
        wb(1'b1, cog_pkg::OFS_RISE, 32'h0000_0001);
        wb(1'b1, cog_pkg::OFS_FALL, 32'h0000_0001);
        run <= 1'b1;
        // steered: routing, period and duty
        wb(1'b1, cog_pkg::OFS_STEER, 32'h0000_0005);
        wb(1'b1, cog_pkg::OFS_CTRL, 32'h0000_0001);
        at(1'b1, 8);
        pins(4'h5, "steered on");
        at(1'b0, 8);
        pins(4'h0, "steered off");
        wb(1'b1, cog_pkg::OFS_STEER, 32'h0000_0004);
        repeat (3) @(posedge clk);
        pins(4'h0, "steer while off");
        at(1'b1, 8);
        wb(1'b1, cog_pkg::OFS_STEER, 32'h0000_0001);
        repeat (3) @(posedge clk);
        pins(4'h1, "steer next cycle");
        // synchronous steered: static data at once, steering at rise
        wb(1'b1, cog_pkg::OFS_CTRL, 32'h0000_0003);
        wb(1'b1, cog_pkg::OFS_STEER, 32'h0000_00F0);
        repeat (3) @(posedge clk);
        pins(4'hF, "static data");
        wb(1'b1, cog_pkg::OFS_STEER, 32'h0000_0001);
        at(1'b1, 8);
        wb(1'b1, cog_pkg::OFS_STEER, 32'h0000_0002);
        repeat (3) @(posedge clk);
        pins(4'h1, "sync steer held");
        at(1'b1, 8);
        pins(4'h2, "sync steer at rise");
        // polarity of output a
        wb(1'b1, cog_pkg::OFS_STEER, 32'h0000_0001);
        wb(1'b1, cog_pkg::OFS_CTRL, 32'h0000_0101);
        at(1'b1, 8);
        pins(4'h0, "inverted on");
        at(1'b0, 8);
        pins(4'h1, "inverted off");
        // bridge, half bridge and undefined modes
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, cog_pkg::OFS_CTRL, {28'h0, tab[i][10:8], 1'b1});
            at(1'b1, 8);
            pins(tab[i][7:4], "mode on");
            at(1'b0, 8);
            pins(tab[i][3:0], "mode off");
        end
        // disabled half bridge
        wb(1'b1, cog_pkg::OFS_CTRL, 32'h0000_0008);
        repeat (4) @(posedge clk);
        pins(4'hA, "disabled");
        // push-pull alternates pairs, first pair a and c
        wb(1'b1, cog_pkg::OFS_CTRL, 32'h0000_000B);
        at(1'b1, 8);
        pins(4'h5, "push first");
        at(1'b0, 8);
        pins(4'h0, "push off");
        at(1'b1, 8);
        pins(4'hA, "push second");
        // direction change delays the modulated output
        wb(1'b1, cog_pkg::OFS_DBAND, 32'h0000_1400);
        wb(1'b1, cog_pkg::OFS_CTRL, 32'h0000_0005);
        at(1'b1, 8);
        pins(4'h9, "forward");
        wb(1'b1, cog_pkg::OFS_CTRL, 32'h0000_0007);
        repeat (3) @(posedge clk);
        pins(4'h4, "dead band hold");
        at(1'b1, 8);
        pins(4'h6, "reverse");
        // phase delay postpones the drive
        wb(1'b1, cog_pkg::OFS_PHASE, 32'h0000_0014);
        wb(1'b1, cog_pkg::OFS_CTRL, 32'h0000_0009);
        at(1'b1, 8);
        pins(4'hA, "phase waiting");
        repeat (20) @(posedge clk);
        pins(4'h5, "phase done");
        wb(1'b1, cog_pkg::OFS_PHASE, 32'h0);
        // shutdown override: a inactive, b low, c high, d high-z
        wb(1'b1, cog_pkg::OFS_SHUT, 32'h0000_E401);
        shut_src <= 4'h1;
        repeat (6) @(posedge clk);
        chk({28'h0, pin_drive}, 32'h0000_0007, "override drive");
        pins(4'h4, "override");
        wb(1'b0, cog_pkg::OFS_SHUT, 32'h0);
        chk(q, 32'h0001_E401, "shut state");
        shut_src <= 4'h0;
        repeat (3) @(posedge clk);
        wb(1'b1, cog_pkg::OFS_SHUT, 32'h0000_E401);
        wb(1'b0, cog_pkg::OFS_SHUT, 32'h0);
        chk(q, 32'h0000_E401, "shut cleared");
        // auto restart clears the shutdown at a rising event
        wb(1'b1, cog_pkg::OFS_SHUT, 32'h0000_E411);
        shut_src <= 4'h1;
        repeat (6) @(posedge clk);
        shut_src <= 4'h0;
        at(1'b1, 8);
        wb(1'b0, cog_pkg::OFS_SHUT, 32'h0);
        chk(q, 32'h0000_E411, "auto restart");
        at(1'b1, 8);
        pins(4'h5, "restored");
        chk({28'h0, pin_drive}, 32'h0000_000F, "drive restored");
        // falling blanked 40 ticks: level source acts late, edge source is lost
        wb(1'b1, cog_pkg::OFS_BLANK, 32'h0000_2800);
        at(1'b1, 8);
        at(1'b0, 8);
        pins(4'h5, "fall blanked");
        repeat (8) @(posedge clk);
        pins(4'h0, "late fall dead band");
        wb(1'b1, cog_pkg::OFS_FALL, 32'h0000_0101);
        at(1'b1, 8);
        at(1'b0, 16);
        pins(4'h5, "edge fall lost");
        final_report;
    end
endmodule
